// ### logic/pmm_pkg.sv
// constants for the program and data memory map block
package pmm_pkg;
   localparam int PC_W       = 13;
   localparam int PROG_AW    = 12;
   localparam int PROG_DW    = 14;
   localparam int DATA_W     = 8;
   localparam int OFF_W      = 7;
   localparam int BANK_W     = 2;
   localparam int DADDR_W    = BANK_W + OFF_W;
   localparam int STORE_AW   = 8;
   localparam int STORE_WORDS = 256;

   localparam logic [PC_W-1:0] PC_RESET  = 13'h0000;
   localparam logic [PC_W-1:0] PC_IRQ    = 13'h0004;
   localparam logic [PC_W-1:0] PC_STEP   = 13'h0001;

   localparam logic [OFF_W-1:0] OFF_LAST     = 7'h7F;
   localparam logic [OFF_W-1:0] OFF_SPECIAL_TOP = 7'h20;
   localparam logic [OFF_W-1:0] OFF_INDIRECT = 7'h00;
   localparam logic [OFF_W-1:0] OFF_STATUS   = 7'h03;
   localparam logic [OFF_W-1:0] OFF_POINTER  = 7'h04;

   localparam int STATUS_BSL_BIT = 5;
   localparam int STATUS_BSH_BIT = 6;
   localparam logic [DATA_W-1:0] STATUS_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO     = 8'h00;
endpackage : pmm_pkg

// ### logic/pmm_store.sv
// general purpose ram storage, registered read data
`timescale 1ns/1ps
`default_nettype none
module pmm_store (
   input  wire logic                             clock,
   input  wire logic                             wr_en,
   input  wire logic [pmm_pkg::STORE_AW-1:0]     addr,
   input  wire logic [pmm_pkg::DATA_W-1:0]       wr_data,
   output var  logic [pmm_pkg::DATA_W-1:0]       rd_data_reg
);
   logic [pmm_pkg::DATA_W-1:0] mem [pmm_pkg::STORE_WORDS];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
   end

   // read-before-write; contents carry no reset, like any static ram
   always_ff @(posedge clock) begin
      rd_data_reg <= mem[addr];
   end
endmodule : pmm_store
`default_nettype wire

// ### logic/pmm_memory_map.sv
// program counter and banked data memory address map
`timescale 1ns/1ps
`default_nettype none
// How it works
// - the program counter is 13 bits and addresses a 4K by 14-bit space.
// - fetch addresses above 4K wrap into the first 4K words.
// - any reset, including the pin master clear, sets the counter to 0000h.
// - taking an interrupt loads the counter with 0004h.
// - the bank bits, high first, pick bank 0 to 3 as 00, 01, 10, 11.
// - each bank spans offsets 00h to 7Fh, 128 bytes.
// - low offsets hold special registers and the rest is general ram.
// - every bank has special registers; status and pointer are mirrored.
// - the shared master clear pin has no driver and flags a change only while master clear is disabled.
// - 256 stored bytes, reached directly or through the pointer register.
module pmm_memory_map (
   input  wire logic                             clock,
   input  wire logic                             rst,
   input  wire logic                             pc_advance,
   input  wire logic                             pc_load,
   input  wire logic [pmm_pkg::PC_W-1:0]         pc_load_value,
   input  wire logic                             irq_take,
   input  wire logic                             data_req,
   input  wire logic                             data_we,
   input  wire logic [pmm_pkg::OFF_W-1:0]        data_offset,
   input  wire logic [pmm_pkg::DATA_W-1:0]       data_wdata,
   input  wire logic                             input_only_port_pin,
   input  wire logic                             master_clear_enable,
   output var  logic [pmm_pkg::PC_W-1:0]         pc_reg,
   output var  logic [pmm_pkg::PROG_AW-1:0]      prog_addr_reg,
   output var  logic                             bank_select_high_reg,
   output var  logic                             bank_select_low_reg,
   output var  logic [pmm_pkg::DATA_W-1:0]       indirect_pointer_reg,
   output var  logic [pmm_pkg::DADDR_W-1:0]      data_addr_reg,
   output var  logic [pmm_pkg::DATA_W-1:0]       data_rdata_reg,
   output var  logic                             data_valid_reg,
   output var  logic                             pin_level_reg,
   output var  logic                             pin_change_reg
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [pmm_pkg::DADDR_W-1:0] full_addr(
      input logic [pmm_pkg::BANK_W-1:0] bank,
      input logic [pmm_pkg::OFF_W-1:0]  off);
      full_addr = {bank, off};
   endfunction : full_addr

   function automatic logic is_special(
      input logic [pmm_pkg::DADDR_W-1:0] addr);
      is_special = addr[pmm_pkg::OFF_W-1:0] < pmm_pkg::OFF_SPECIAL_TOP;
   endfunction : is_special

   ////////////////////////////////////////////////////////////////////////
   logic                              master_clear_active;
   logic                              sys_reset;
   logic [pmm_pkg::PC_W-1:0]          pc_next;
   logic [pmm_pkg::DATA_W-1:0]        status_reg;
   logic [pmm_pkg::BANK_W-1:0]        bank_sel;
   logic [pmm_pkg::DADDR_W-1:0]       direct_addr;
   logic [pmm_pkg::DADDR_W-1:0]       eff_addr;
   logic [pmm_pkg::OFF_W-1:0]         eff_off;
   logic                              via_pointer;
   logic                              eff_special;
   logic                              gpr_write;
   logic [pmm_pkg::DATA_W-1:0]        store_rdata_reg;
   logic [pmm_pkg::DATA_W-1:0]        special_rdata_reg;
   logic                              special_sel_reg;
   logic                              stage1_valid_reg;

   // pin low while master clear is enabled acts as a reset
   assign master_clear_active = master_clear_enable & ~input_only_port_pin;
   assign sys_reset = rst | master_clear_active;

   ////////////////////////////////////////////////////////////////////////
   // program counter
   always_comb begin
      if (sys_reset) begin
         pc_next = pmm_pkg::PC_RESET;
      end else if (irq_take) begin
         pc_next = pmm_pkg::PC_IRQ;
      end else if (pc_load) begin
         pc_next = pc_load_value;
      end else if (pc_advance) begin
         pc_next = pc_reg + pmm_pkg::PC_STEP;
      end else begin
         pc_next = pc_reg;
      end
   end

   always_ff @(posedge clock) begin
      pc_reg <= pc_next;
   end

   // dropping bit 12 folds the upper 4K onto the implemented words
   always_ff @(posedge clock) begin
      prog_addr_reg <= pc_next[pmm_pkg::PROG_AW-1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // address resolution
   assign bank_sel = {status_reg[pmm_pkg::STATUS_BSH_BIT],
                      status_reg[pmm_pkg::STATUS_BSL_BIT]};
   assign direct_addr = full_addr(bank_sel, data_offset);
   assign via_pointer = data_offset == pmm_pkg::OFF_INDIRECT;
   // indirect reach uses the high bank bit above the 8-bit pointer
   assign eff_addr = via_pointer ?
      {status_reg[pmm_pkg::STATUS_BSH_BIT], indirect_pointer_reg} :
      direct_addr;
   assign eff_off = eff_addr[pmm_pkg::OFF_W-1:0];
   assign eff_special = is_special(eff_addr);
   assign gpr_write = data_req & data_we & ~eff_special;

   always_ff @(posedge clock) begin
      bank_select_high_reg <= sys_reset ? 1'h0 : bank_sel[1];
      bank_select_low_reg  <= sys_reset ? 1'h0 : bank_sel[0];
   end

   ////////////////////////////////////////////////////////////////////////
   // special registers: status and pointer answer in every bank
   always_ff @(posedge clock) begin
      if (sys_reset) begin
         status_reg <= pmm_pkg::STATUS_RESET;
      end else if (data_req && data_we && eff_off == pmm_pkg::OFF_STATUS) begin
         status_reg <= data_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_reset) begin
         indirect_pointer_reg <= pmm_pkg::POINTER_RESET;
      end else if (data_req && data_we &&
                   eff_off == pmm_pkg::OFF_POINTER) begin
         indirect_pointer_reg <= data_wdata;
      end
   end

   // unimplemented special offsets, and the pointer aimed at the
   // indirect slot itself, read as zero and ignore writes
   always_ff @(posedge clock) begin
      if (sys_reset) begin
         special_rdata_reg <= pmm_pkg::READ_ZERO;
      end else if (data_req) begin
         unique case (eff_off)
            pmm_pkg::OFF_STATUS:  special_rdata_reg <= status_reg;
            pmm_pkg::OFF_POINTER: special_rdata_reg <= indirect_pointer_reg;
            default:              special_rdata_reg <= pmm_pkg::READ_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // general purpose ram, 256 bytes indexed by the low address byte
   pmm_store u_store (
      .clock       (clock),
      .wr_en       (gpr_write),
      .addr        (eff_addr[pmm_pkg::STORE_AW-1:0]),
      .wr_data     (data_wdata),
      .rd_data_reg (store_rdata_reg)
   );

   ////////////////////////////////////////////////////////////////////////
   // two-stage read pipe so the answer leaves from a flop
   always_ff @(posedge clock) begin
      if (sys_reset) begin
         data_addr_reg <= '0;
         special_sel_reg <= 1'h0;
      end else if (data_req) begin
         data_addr_reg <= eff_addr;
         special_sel_reg <= eff_special;
      end
   end

   always_ff @(posedge clock) begin
      stage1_valid_reg <= ~sys_reset & data_req;
      data_valid_reg   <= ~sys_reset & stage1_valid_reg;
   end

   always_ff @(posedge clock) begin
      if (sys_reset) begin
         data_rdata_reg <= pmm_pkg::READ_ZERO;
      end else if (stage1_valid_reg) begin
         data_rdata_reg <= special_sel_reg ? special_rdata_reg :
                           store_rdata_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input-only pin: sampled only, change flagged unless master clear
   always_ff @(posedge clock) begin
      pin_level_reg <= input_only_port_pin;
   end

   always_ff @(posedge clock) begin
      pin_change_reg <= ~rst & ~master_clear_enable &
                        (input_only_port_pin != pin_level_reg);
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_read_req;
      data_req && !sys_reset;
   endsequence

   sequence s_read_done;
      ##2 data_valid_reg;
   endsequence

   a_pc_reset: assert property (@(posedge clock)
      sys_reset |=> pc_reg == pmm_pkg::PC_RESET && prog_addr_reg == '0)
      else $error("counter not at reset vector after reset");

   a_irq_vector: assert property (@(posedge clock)
      disable iff (rst) irq_take && !master_clear_active
      |=> pc_reg == pmm_pkg::PC_IRQ)
      else $error("interrupt did not load vector 0004h");

   a_fetch_wrap: assert property (@(posedge clock)
      disable iff (rst) prog_addr_reg == pc_reg[pmm_pkg::PROG_AW-1:0])
      else $error("fetch address not folded into first 4K");

   a_pc_step: assert property (@(posedge clock)
      disable iff (rst) !master_clear_active && !irq_take && !pc_load &&
      pc_advance |=> pc_reg == $past(pc_reg) + pmm_pkg::PC_STEP)
      else $error("counter did not step by one");

   a_bank_decode: assert property (@(posedge clock)
      disable iff (sys_reset) ##1 bank_select_high_reg ==
      $past(status_reg[pmm_pkg::STATUS_BSH_BIT]) && bank_select_low_reg ==
      $past(status_reg[pmm_pkg::STATUS_BSL_BIT]))
      else $error("bank outputs disagree with status bits");

   a_direct_addr: assert property (@(posedge clock)
      disable iff (sys_reset) data_req && !via_pointer
      |=> data_addr_reg == {$past(bank_sel), $past(data_offset)})
      else $error("direct address not bank over offset");

   a_indirect_addr: assert property (@(posedge clock)
      disable iff (sys_reset) data_req && via_pointer
      |=> data_addr_reg[pmm_pkg::STORE_AW-1:0] == $past(indirect_pointer_reg))
      else $error("indirect access ignored pointer");

   a_read_latency: assert property (@(posedge clock)
      disable iff (sys_reset) s_read_req |-> s_read_done)
      else $error("read answer not two cycles after request");

   a_pointer_mirror: assert property (@(posedge clock)
      disable iff (sys_reset) data_req && data_we && !via_pointer &&
      data_offset == pmm_pkg::OFF_POINTER
      |=> indirect_pointer_reg == $past(data_wdata))
      else $error("pointer not reached from this bank");

   a_special_zone: assert property (@(posedge clock)
      disable iff (sys_reset) special_sel_reg |->
      data_addr_reg[pmm_pkg::OFF_W-1:0] < pmm_pkg::OFF_SPECIAL_TOP)
      else $error("special select outside low offsets");

   a_pin_change: assert property (@(posedge clock)
      disable iff (rst) !master_clear_enable &&
      input_only_port_pin != pin_level_reg |=> pin_change_reg)
      else $error("pin change not flagged");
endmodule : pmm_memory_map
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the program and data memory map block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clock, rst, pc_advance, pc_load, irq_take;
   logic        data_req, data_we, input_only_port_pin, master_clear_enable;
   logic [12:0] pc_load_value, pc_reg, pc_exp;
   logic [6:0]  data_offset;
   logic [7:0]  data_wdata, indirect_pointer_reg, data_rdata_reg, ptr_exp;
   logic [11:0] prog_addr_reg;
   logic [8:0]  data_addr_reg;
   logic        bank_select_high_reg, bank_select_low_reg, data_valid_reg;
   logic        pin_level_reg, pin_change_reg;
   logic [1:0]  bank_exp, b;
   logic [6:0]  off;
   logic [7:0]  mem_exp [256];
   int          err_count = 0;
   int          samples_checked = 0;
   int          seed = 51306;
   int          cycles = 0;

   pmm_memory_map u_dut (.clock(clock), .rst(rst), .pc_advance(pc_advance),
      .pc_load(pc_load), .pc_load_value(pc_load_value),
      .irq_take(irq_take), .data_req(data_req), .data_we(data_we),
      .data_offset(data_offset), .data_wdata(data_wdata),
      .input_only_port_pin(input_only_port_pin),
      .master_clear_enable(master_clear_enable), .pc_reg(pc_reg),
      .prog_addr_reg(prog_addr_reg),
      .bank_select_high_reg(bank_select_high_reg),
      .bank_select_low_reg(bank_select_low_reg),
      .indirect_pointer_reg(indirect_pointer_reg),
      .data_addr_reg(data_addr_reg), .data_rdata_reg(data_rdata_reg),
      .data_valid_reg(data_valid_reg), .pin_level_reg(pin_level_reg),
      .pin_change_reg(pin_change_reg));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   // the whole run needs about 1340 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic step();
      @(posedge clock);
      #10;
   endtask : step

   task automatic pc_op(input logic adv, ld, irq, input logic [12:0] val);
      pc_advance = adv;
      pc_load = ld;
      irq_take = irq;
      pc_load_value = val;
      if (irq) pc_exp = 13'h0004;
      else if (ld) pc_exp = val;
      else if (adv) pc_exp = pc_exp + 13'h0001;
      step();
      check("pc", {3'h0, pc_reg}, {3'h0, pc_exp});
      check("fetch", {4'h0, prog_addr_reg}, {4'h0, pc_exp[11:0]});
   endtask : pc_op

   // offset 00h goes through the pointer, high bank bit on top
   function automatic logic [8:0] eff_addr(input logic [6:0] o);
      return (o == 7'h00) ? {bank_exp[1], ptr_exp} : {bank_exp, o};
   endfunction : eff_addr

   function automatic logic [7:0] exp_read(input logic [8:0] ea);
      if (ea[6:0] >= 7'h20) return mem_exp[ea[7:0]];
      if (ea[6:0] == 7'h03) return {1'b0, bank_exp, 5'h00};
      if (ea[6:0] == 7'h04) return ptr_exp;
      return 8'h00;
   endfunction : exp_read

   task automatic xfer(input logic we, input logic [6:0] o,
                       input logic [7:0] wd);
      logic [8:0] ea;
      ea = eff_addr(o);
      data_req = 1'b1;
      data_we = we;
      data_offset = o;
      data_wdata = wd;
      step();
      data_req = 1'b0;
      check("daddr", {7'h0, data_addr_reg}, {7'h0, ea});
      step();
      check("valid", {15'h0, data_valid_reg}, 16'h0001);
      if (!we) check("rdata", {8'h0, data_rdata_reg},
                     {8'h0, exp_read(ea)});
      if (we && ea[6:0] >= 7'h20) mem_exp[ea[7:0]] = wd;
      if (we && o == 7'h04) ptr_exp = wd;
      if (we && o == 7'h03) bank_exp = wd[6:5];
      check("ptr", {8'h0, indirect_pointer_reg}, {8'h0, ptr_exp});
      step();
      check("valid end", {15'h0, data_valid_reg}, 16'h0000);
      check("bank", {14'h0, bank_select_high_reg, bank_select_low_reg},
            {14'h0, bank_exp});
   endtask : xfer

   initial begin
      rst = 1'b1;
      {pc_advance, pc_load, irq_take, data_req, data_we} = 5'h00;
      {pc_load_value, data_offset, data_wdata} = 28'h0000000;
      input_only_port_pin = 1'b1;
      master_clear_enable = 1'b0;
      {pc_exp, bank_exp, ptr_exp} = 23'h000000;
      repeat (4) step();
      rst = 1'b0;
      check("reset pc", {3'h0, pc_reg}, 16'h0000);
      pc_op(1'b0, 1'b1, 1'b0, 13'h1FFE);
      pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
      pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
      pc_op(1'b1, 1'b1, 1'b1, 13'h0123);
      repeat (200) pc_op(1'($random(seed)), 1'($random(seed)),
                         ($random(seed) & 7) == 0, 13'($random(seed)));
      // mid-run reset while the counter controls are still busy
      rst = 1'b1;
      step();
      {pc_advance, pc_load, irq_take} = 3'h0;
      rst = 1'b0;
      {pc_exp, bank_exp, ptr_exp} = 23'h000000;
      check("rerun pc", {3'h0, pc_reg}, 16'h0000);
      check("rerun fetch", {4'h0, prog_addr_reg}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, 7'h03, {1'b0, 2'(i), 5'h00});
         xfer(1'b0, 7'h03, 8'h00);
         xfer(1'b0, 7'h04, 8'h00);
      end
      xfer(1'b1, 7'h10, 8'hA5);
      xfer(1'b0, 7'h10, 8'h00);
      xfer(1'b1, 7'h04, 8'h80);
      xfer(1'b0, 7'h00, 8'h00);
      repeat (60) begin
         b = 2'($random(seed));
         off = 7'h20 + 7'($unsigned($random(seed)) % 96);
         if (off[0]) off = {off[6:1], 1'b1} | 7'h7F;
         xfer(1'b1, 7'h03, {1'b0, b, 5'h00});
         xfer(1'b1, off, 8'($random(seed)));
         xfer(1'b1, 7'h03, {1'b0, ~b[1], b[0], 5'h00});
         xfer(1'b0, off, 8'h00);
         xfer(1'b1, 7'h04, {b[0], off});
         xfer(1'b0, 7'h00, 8'h00);
      end
      input_only_port_pin = 1'b0;
      step();
      check("pin", {14'h0, pin_level_reg, pin_change_reg}, 16'h0001);
      step();
      check("pin pulse", {15'h0, pin_change_reg}, 16'h0000);
      pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
      master_clear_enable = 1'b1;
      step();
      check("master_clear_input pc", {3'h0, pc_reg}, 16'h0000);
      check("master_clear_input ptr", {8'h0, indirect_pointer_reg}, 16'h0000);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
